// ---- core/swc_map.svh ----
// Address map and constants of the sleep and wake-up controller.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_OFS_CTRL     12'h000
`define SWC_OFS_STATUS   12'h004
`define SWC_OFS_IRQ_EN   12'h008
`define SWC_OFS_SLEEPCAP 12'h00c
`define SWC_OFS_PC       12'h010
`define SWC_ADDR_MSB     11
`define SWC_NIRQ         8
`define SWC_PC_W         15
`define SWC_CTRL_PINRST_EN 0
`define SWC_CTRL_BOR_EN    1
`define SWC_CTRL_WDT_EN    2
`define SWC_CTRL_GIE       3
`define SWC_CAUSE_W      3
`define SWC_CAUSE_NONE   3'h0
`define SWC_CAUSE_PIN    3'h1
`define SWC_CAUSE_BOR    3'h2
`define SWC_CAUSE_POR    3'h3
`define SWC_CAUSE_WDT    3'h4
`define SWC_CAUSE_EXT    3'h5
`define SWC_CAUSE_PERIPH 3'h6
`define SWC_RESP_OKAY    2'h0
`define SWC_RESP_SLVERR  2'h2
`define SWC_PC_ONE       15'h0001
`define SWC_ISR_VECTOR   15'h0004
`define SWC_IRQ_RESET    8'h00
`define SWC_CAP_RESET    8'h00
`endif

// ---- core/swc_pkg.sv ----
// Types shared by the sleep and wake-up controller files.
// Assumes the constants header is included alongside it.
`include "swc_map.svh"
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN    = 2'b00,
    SWC_SLEEP  = 2'b01,
    SWC_RESUME = 2'b10,
    SWC_VECTOR = 2'b11
  } swc_state_t;
  typedef struct packed {
    logic pin_reset;
    logic brownout_reset;
    logic por_reset;
    logic wdt_timeout;
    logic ext_irq;
    logic [`SWC_NIRQ-1:0] periph_irq;
  } swc_events_t;
  typedef struct packed {
    logic                 sleep_exec;
    logic [`SWC_PC_W-1:0] pc;
  } swc_core_req_t;
  typedef struct packed {
    logic                 halt;
    logic                 fetch_en;
    logic [`SWC_PC_W-1:0] fetch_addr;
    logic                 exec_prefetched;
    logic                 call_isr;
    logic [`SWC_PC_W-1:0] isr_vector;
  } swc_core_ctl_t;
endpackage

// ---- core/swc_wake_detect.sv ----
// Wake-event qualifier: picks the wake cause from the pending events.
// Assumes all event inputs are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module swc_wake_detect (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire swc_pkg::swc_events_t    events,
  input  wire logic [`SWC_NIRQ-1:0]    irq_en,
  input  wire logic [`SWC_NIRQ-1:0]    sleep_cap,
  input  wire logic                    pinrst_en,
  input  wire logic                    bor_en,
  input  wire logic                    wdt_en,
  output logic                         wake_reset,
  output logic                         wake_resume,
  output logic [`SWC_CAUSE_W-1:0]      cause
);
  import swc_pkg::*;
  logic [`SWC_NIRQ-1:0] periph_ok;
  logic                 any_periph;

  // Each peripheral line counts only when enabled and able to run in sleep.
  genvar i;
  generate
    for (i = 0; i < `SWC_NIRQ; i++) begin : g_periph
      assign periph_ok[i] = events.periph_irq[i] & irq_en[i] & sleep_cap[i];
    end
  endgenerate
  assign any_periph = |periph_ok;

  // Cause is registered; reset-type events take priority over resume events.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reset  <= 1'b0;
      wake_resume <= 1'b0;
      cause       <= `SWC_CAUSE_NONE;
    end else begin
      wake_reset  <= (events.pin_reset & pinrst_en) | (events.brownout_reset & bor_en)
                     | events.por_reset;
      wake_resume <= (events.wdt_timeout & wdt_en) | events.ext_irq | any_periph;
      if (events.por_reset) begin
        cause <= `SWC_CAUSE_POR;
      end else if (events.brownout_reset & bor_en) begin
        cause <= `SWC_CAUSE_BOR;
      end else if (events.pin_reset & pinrst_en) begin
        cause <= `SWC_CAUSE_PIN;
      end else if (events.wdt_timeout & wdt_en) begin
        cause <= `SWC_CAUSE_WDT;
      end else if (events.ext_irq) begin
        cause <= `SWC_CAUSE_EXT;
      end else if (any_periph) begin
        cause <= `SWC_CAUSE_PERIPH;
      end else begin
        cause <= `SWC_CAUSE_NONE;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/swc_sleep_ctrl.sv ----
// Sleep and wake-up controller top: sequences sleep entry and exit for the core.
// Assumes a core that reports sleep execution and obeys halt and fetch controls.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module swc_sleep_ctrl (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`SWC_ADDR_MSB:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`SWC_ADDR_MSB:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire swc_pkg::swc_events_t  events,
  input  wire swc_pkg::swc_core_req_t core_req,
  output swc_pkg::swc_core_ctl_t     core_ctl,
  output logic                       main_clk_gate,
  output logic                       device_reset_req,
  output logic                       windowed_watchdog_clear
);
  import swc_pkg::*;

  swc_state_t            state;
  logic [3:0]            ctrl;
  logic [`SWC_NIRQ-1:0]  irq_en;
  logic [`SWC_NIRQ-1:0]  sleep_cap;
  logic [`SWC_PC_W-1:0]  sleep_pc;
  logic [`SWC_CAUSE_W-1:0] last_cause;
  logic                  wake_reset;
  logic                  wake_resume;
  logic [`SWC_CAUSE_W-1:0] cause;
  logic                  aw_held;
  logic                  w_held;
  logic [`SWC_ADDR_MSB:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic [31:0]           next_rdata;
  logic                  rd_hit;

  swc_wake_detect u_detect (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .events      (events),
    .irq_en      (irq_en),
    .sleep_cap   (sleep_cap),
    .pinrst_en   (ctrl[`SWC_CTRL_PINRST_EN]),
    .bor_en      (ctrl[`SWC_CTRL_BOR_EN]),
    .wdt_en      (ctrl[`SWC_CTRL_WDT_EN]),
    .wake_reset  (wake_reset),
    .wake_resume (wake_resume),
    .cause       (cause)
  );

  // Write address and data are caught independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data holding register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Ready is offered only while the holding slot is empty.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write response; unmapped offsets answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SWC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        `SWC_OFS_CTRL, `SWC_OFS_IRQ_EN, `SWC_OFS_SLEEPCAP: s_axi_bresp <= `SWC_RESP_OKAY;
        `SWC_OFS_STATUS, `SWC_OFS_PC:                      s_axi_bresp <= `SWC_RESP_OKAY;
        default:                                           s_axi_bresp <= `SWC_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers, written through the low byte lane.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= 4'h0;
      irq_en    <= `SWC_IRQ_RESET;
      sleep_cap <= `SWC_CAP_RESET;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        `SWC_OFS_CTRL:     ctrl      <= w_data[3:0];
        `SWC_OFS_IRQ_EN:   irq_en    <= w_data[`SWC_NIRQ-1:0];
        `SWC_OFS_SLEEPCAP: sleep_cap <= w_data[`SWC_NIRQ-1:0];
        default:           ctrl      <= ctrl;
      endcase
    end
  end

  // Read data mux over the register map.
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (s_axi_araddr)
      `SWC_OFS_CTRL:     next_rdata[3:0] = ctrl;
      `SWC_OFS_STATUS:   next_rdata[4:0] = {last_cause, state};
      `SWC_OFS_IRQ_EN:   next_rdata[`SWC_NIRQ-1:0] = irq_en;
      `SWC_OFS_SLEEPCAP: next_rdata[`SWC_NIRQ-1:0] = sleep_cap;
      `SWC_OFS_PC:       next_rdata[`SWC_PC_W-1:0] = sleep_pc;
      default:           rd_hit = 1'b0;
    endcase
  end

  // Read channel: one cycle to accept, answer on the same edge as the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SWC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Sleep state machine; reset-type wake outranks resume-type wake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SWC_RUN;
    end else begin
      unique case (state)
        SWC_RUN: begin
          if (core_req.sleep_exec) begin
            state <= SWC_SLEEP;
          end
        end
        SWC_SLEEP: begin
          if (wake_reset) begin
            state <= SWC_RUN;
          end else if (wake_resume) begin
            state <= SWC_RESUME;
          end
        end
        SWC_RESUME: begin
          state <= ctrl[`SWC_CTRL_GIE] ? SWC_VECTOR : SWC_RUN;
        end
        SWC_VECTOR: begin
          state <= SWC_RUN;
        end
      endcase
    end
  end

  // Capture the prefetch address at sleep entry and the wake cause at exit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_pc   <= '0;
      last_cause <= `SWC_CAUSE_NONE;
    end else begin
      if (state == SWC_RUN && core_req.sleep_exec) begin
        sleep_pc <= core_req.pc + `SWC_PC_ONE;
      end
      if (state == SWC_SLEEP && (wake_reset || wake_resume)) begin
        last_cause <= cause;
      end
    end
  end

  // Core controls, main clock gate, reset request and watchdog clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ctl         <= '0;
      main_clk_gate    <= 1'b0;
      device_reset_req <= 1'b0;
      windowed_watchdog_clear       <= 1'b0;
    end else begin
      core_ctl.isr_vector      <= `SWC_ISR_VECTOR;
      core_ctl.fetch_addr      <= sleep_pc;
      core_ctl.halt            <= (state == SWC_SLEEP) && !wake_reset && !wake_resume;
      core_ctl.fetch_en        <= (state != SWC_SLEEP);
      core_ctl.exec_prefetched <= (state == SWC_RESUME);
      core_ctl.call_isr        <= (state == SWC_VECTOR);
      // Only the main-clock domain is gated; other clock sources keep running.
      main_clk_gate            <= (state == SWC_SLEEP) && !wake_reset && !wake_resume;
      device_reset_req         <= (state == SWC_SLEEP) && wake_reset;
      windowed_watchdog_clear               <= (state == SWC_SLEEP) && (wake_reset || wake_resume);
    end
  end
endmodule
`default_nettype wire

// ---- verification/swc_properties.sv ----
// Port checker for the sleep and wake-up controller top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module swc_properties (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire swc_pkg::swc_events_t   events,
  input wire swc_pkg::swc_core_req_t core_req,
  input wire swc_pkg::swc_core_ctl_t core_ctl,
  input wire logic                   main_clk_gate,
  input wire logic                   device_reset_req,
  input wire logic                   windowed_watchdog_clear
);
  import swc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A quiet sleeping cycle, and the first step of a wake that resumes the program.
  sequence s_quiet; core_ctl.halt && events == '0; endsequence
  sequence s_resume; windowed_watchdog_clear && !device_reset_req; endsequence
  // Sleep entry, wake order and pulse shapes.
  property p_halt; $rose(core_ctl.halt) |-> $past(core_req.sleep_exec, 2) && main_clk_gate;
  endproperty
  property p_addr; $rose(core_ctl.halt) |-> core_ctl.fetch_addr == $past(core_req.pc, 2) + 15'h0001;
  endproperty
  property p_isr; core_ctl.call_isr |-> $past(core_ctl.exec_prefetched) && core_ctl.isr_vector == 15'h0004;
  endproperty
  property p_rstclr; device_reset_req |-> windowed_watchdog_clear; endproperty
  property p_pulse; windowed_watchdog_clear |=> !windowed_watchdog_clear; endproperty
  property p_por; $rose(events.por_reset) && core_ctl.halt |-> ##[1:4] device_reset_req; endproperty
  property p_ext; $rose(events.ext_irq) && core_ctl.halt && events[12:10] == 3'h0 |-> ##[1:4] s_resume;
  endproperty
  property p_quiet; s_quiet [*3] |=> !windowed_watchdog_clear; endproperty
  property p_exec; s_resume |=> core_ctl.exec_prefetched; endproperty
  a_halt: assert property (p_halt) else $error("Halt rose without a sleep request.");
  a_addr: assert property (p_addr) else $error("Prefetch address is not pc plus one.");
  a_isr: assert property (p_isr) else $error("Handler call out of order.");
  a_rstclr: assert property (p_rstclr) else $error("Reset wake without watchdog clear.");
  a_pulse: assert property (p_pulse) else $error("Watchdog clear longer than one cycle.");
  a_por: assert property (p_por) else $error("Power-on event did not reset.");
  a_ext: assert property (p_ext) else $error("External interrupt did not resume.");
  a_quiet: assert property (p_quiet) else $error("Wake without any event.");
  a_exec: assert property (p_exec) else $error("Prefetched word not run on resume.");
endmodule
bind swc_sleep_ctrl swc_properties u_props (.aclk(aclk), .aresetn(aresetn), .events(events),
  .core_req(core_req), .core_ctl(core_ctl), .main_clk_gate(main_clk_gate),
  .device_reset_req(device_reset_req), .windowed_watchdog_clear(windowed_watchdog_clear));
`default_nettype wire

// ---- verification/swc_core_model.sv ----
// Behavioural core on the far side: issues sleep instructions on command.
// Assumes the bench pulses sleep_cmd for one cycle while the core runs.
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   sleep_cmd,
  input  wire logic [14:0]            sleep_pc,
  input  wire swc_pkg::swc_core_ctl_t core_ctl,
  output var  swc_pkg::swc_core_req_t core_req
);
  import swc_pkg::*;
  // A halted core runs nothing; the word after each sleep is a no-operation.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_req <= '0;
    end else begin
      core_req.sleep_exec <= sleep_cmd && !core_ctl.halt;
      core_req.pc         <= sleep_pc;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_sleep_wakeup_control.sv ----
// Bench for the sleep and wake-up controller: register access and wake cases.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wakeup_control;
  import swc_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [11:0]   awaddr = '0, araddr = '0;
  logic [31:0]   wdata = '0, rdata;
  logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic          awready, wready, bvalid, arready, rvalid, gate, rst_req, clr;
  logic [1:0]    bresp, rresp, r;
  logic          sleep_cmd = 1'b0;
  logic [14:0]   sleep_pc = 15'h0100;
  swc_events_t   events = '0;
  swc_core_req_t core_req;
  swc_core_ctl_t core_ctl;
  int            num_errors = 0, checks = 0, n_clr = 0, n_rst = 0, n_pre = 0, n_isr = 0;
  // Clock and pulse counters.
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    n_clr += clr;
    n_rst += rst_req;
    n_pre += core_ctl.exec_prefetched;
    n_isr += core_ctl.call_isr;
  end
  swc_sleep_ctrl dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .core_req(core_req), .core_ctl(core_ctl),
    .main_clk_gate(gate), .device_reset_req(rst_req), .windowed_watchdog_clear(clr));
  swc_core_model core (.aclk(aclk), .aresetn(aresetn), .sleep_cmd(sleep_cmd),
    .sleep_pc(sleep_pc), .core_ctl(core_ctl), .core_req(core_req));
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus write: address and data offered together, each released when taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  // Bus read with expected data and response.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // One sleep with one set of events; x is {wake, reset, handler call}.
  task automatic run_case(input logic [3:0] c, input logic [7:0] en, input logic [7:0] cap,
                          input logic [12:0] ev, input logic [2:0] x, input logic [2:0] cs);
    int b[4];
    int k;
    axw(12'h000, {28'h0, c}, r);
    axw(12'h008, {24'h0, en}, r);
    axw(12'h00c, {24'h0, cap}, r);
    sleep_cmd <= 1'b1;
    sleep_pc <= sleep_pc + 15'h0011;
    @(posedge aclk);
    sleep_cmd <= 1'b0;
    for (k = 0; k < 20 && core_ctl.halt !== 1'b1; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk({31'h0, gate}, 32'h1);
    chk({31'h0, core_ctl.fetch_en}, 32'h0);
    b = '{n_clr, n_rst, n_pre, n_isr};
    events <= ev;
    repeat (12) @(posedge aclk);
    events <= '0;
    chk(n_clr - b[0], {31'h0, x[2]});
    chk(n_rst - b[1], {31'h0, x[1]});
    chk(n_pre - b[2], {31'h0, x[2] & !x[1]});
    chk(n_isr - b[3], {31'h0, x[0]});
    chk({31'h0, core_ctl.halt}, {31'h0, !x[2]});
    if (!x[2]) begin
      events <= 13'h0100;
      repeat (12) @(posedge aclk);
      events <= '0;
    end else rd(12'h004, {27'h0, cs, 2'b00}, 2'h0);
    rd(12'h010, {17'h0, sleep_pc + 15'h0001}, 2'h0);
  endtask
  // Reset, register access, then the wake table.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h004, 32'h0, 2'h0);
    rd(12'h008, 32'h0, 2'h0);
    rd(12'h00c, 32'h0, 2'h0);
    rd(12'h020, 32'h0, 2'h2);
    axw(12'h020, 32'hf, r);
    chk({30'h0, r}, 32'h2);
    axw(12'h004, 32'hff, r);
    rd(12'h004, 32'h0, 2'h0);
    axw(12'h000, 32'hf, r);
    rd(12'h000, 32'hf, 2'h0);
    run_case(4'h1, 8'h00, 8'h00, 13'h1000, 3'b110, 3'h1);
    run_case(4'h0, 8'h00, 8'h00, 13'h1000, 3'b000, 3'h0);
    run_case(4'h2, 8'h00, 8'h00, 13'h0800, 3'b110, 3'h2);
    run_case(4'h0, 8'h00, 8'h00, 13'h0800, 3'b000, 3'h0);
    run_case(4'h0, 8'h00, 8'h00, 13'h0400, 3'b110, 3'h3);
    run_case(4'h4, 8'h00, 8'h00, 13'h0200, 3'b100, 3'h4);
    run_case(4'h0, 8'h00, 8'h00, 13'h0200, 3'b000, 3'h0);
    run_case(4'h0, 8'h00, 8'h00, 13'h0100, 3'b100, 3'h5);
    run_case(4'h8, 8'h00, 8'h00, 13'h0100, 3'b101, 3'h5);
    run_case(4'h8, 8'h80, 8'h80, 13'h0080, 3'b101, 3'h6);
    run_case(4'h0, 8'h80, 8'h00, 13'h0080, 3'b000, 3'h0);
    run_case(4'h8, 8'h00, 8'h80, 13'h0080, 3'b000, 3'h0);
    run_case(4'h9, 8'h00, 8'h00, 13'h1100, 3'b110, 3'h1);
    wrap_up();
  end
  // Cuts a hang short.
  initial begin
    repeat (6000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
